// >>> blink_pkg.sv
// constants and types for the fault blink annunciator
package blink_pkg;

  // ---------------------------------------------------------------
  // clock and time base
  // ---------------------------------------------------------------
  localparam int CLK_HZ         = 20_000_000;
  localparam int SEC_S          = 1;
  localparam int SEC_CYCLES     = CLK_HZ * SEC_S;
  localparam int HOUR_SECS      = 3600;
  localparam int HOURS_LIMIT    = 200;
  localparam int RUN_WINDOW_S   = 15;
  localparam int START_WAIT     = 3;

  // ---------------------------------------------------------------
  // blink timing defaults in milliseconds and derived cycles
  // ---------------------------------------------------------------
  localparam int FAST_MS        = 200;
  localparam int SLOW_MS        = 600;
  localparam int PAUSE_MS       = 1500;
  localparam int FAST_CYCLES    = CLK_HZ / 1000 * FAST_MS;
  localparam int SLOW_CYCLES    = CLK_HZ / 1000 * SLOW_MS;
  localparam int PAUSE_CYCLES   = CLK_HZ / 1000 * PAUSE_MS;
  localparam logic [7:0] FLAME_MAX_RST = 8'hf0;

  // ---------------------------------------------------------------
  // pilot proving period in seconds
  // ---------------------------------------------------------------
  localparam logic [3:0] PILOT_INTACT_S  = 4'ha;
  localparam logic [3:0] PILOT_CLIPPED_S = 4'h4;

  // ---------------------------------------------------------------
  // fault codes as tens and units digits
  // ---------------------------------------------------------------
  localparam logic [7:0] CODE_NO_FLAME    = 8'h22;
  localparam logic [7:0] CODE_FALSE_FLAME = 8'h21;
  localparam logic [7:0] CODE_OVERRANGE   = 8'h23;
  localparam logic [7:0] CODE_AIRFLOW     = 8'h31;
  localparam logic [7:0] CODE_JUMPER      = 8'h44;
  localparam logic [7:0] CODE_110         = 8'hb0;

  // ---------------------------------------------------------------
  // register byte offsets and interrupt bits
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] STATUS_OFS    = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS  = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS  = 8'h0c;
  localparam logic [7:0] FAST_OFS      = 8'h10;
  localparam logic [7:0] SLOW_OFS      = 8'h14;
  localparam logic [7:0] PAUSE_OFS     = 8'h18;
  localparam logic [7:0] FLAME_MAX_OFS = 8'h1c;
  localparam int IRQ_LOCK    = 0;
  localparam int IRQ_RECYCLE = 1;
  localparam int IRQ_PERM    = 2;

  typedef enum logic [2:0] {
    B_IDLE, B_ON, B_OFF, B_GAP, B_PAUSE
  } blink_t;

endpackage : blink_pkg

// >>> fault_blink_annunciator.sv
// fault blink annunciator with jumper supervision and wishbone registers
`timescale 1ns/1ps
module fault_blink_annunciator
  import blink_pkg::*;
#(
  parameter int SEC_CYCLES_P = SEC_CYCLES,
  parameter int HOUR_SECS_P  = HOUR_SECS
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o,
  // pins: jumpers (1 = intact), reset button, saved lockout
  input  wire logic [2:0]  jumper_intact_i,
  input  wire logic        reset_btn_i,
  input  wire logic        lockout_saved_i,
  input  wire logic [7:0]  saved_code_i,
  // sequencer events, same clock
  input  wire logic        flame_present_i,
  input  wire logic        standby_purge_i,
  input  wire logic        in_run_i,
  input  wire logic [7:0]  flame_level_i,
  input  wire logic        flame_fail_i,
  input  wire logic        airflow_fail_i,
  // indications and actions
  output logic             power_led_o,
  output logic             lockout_o,
  output logic [7:0]       fault_code_o,
  output logic             recycle_o,
  output logic [3:0]       pilot_period_s_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    blink_t      bst;
    logic        slow_ph;
    logic [25:0] cnt;
    logic [3:0]  left;
    logic [2:0]  j1;
    logic [2:0]  j2;
    logic [2:0]  jsamp;
    logic        b1;
    logic        b2;
    logic        b3;
    logic [8:0]  sv1;
    logic [8:0]  sv2;
    logic [1:0]  start;
    logic        started;
    logic        locked;
    logic        perm;
    logic [7:0]  code;
    logic [24:0] pre;
    logic [11:0] secs;
    logic [7:0]  hours;
    logic [3:0]  run_s;
    logic        special;
    logic [25:0] fast;
    logic [25:0] slow;
    logic [25:0] pause;
    logic [7:0]  fmax;
    logic [2:0]  irq;
    logic [2:0]  mask;
    logic        ack;
    logic [31:0] dat;
    logic        irq_out;
    logic        led;
    logic        recycle;
    logic [3:0]  pilot_s;
  } state_t;

  state_t st;
  state_t next_st;

  logic        sec_tick;
  logic        hour_tick;
  logic        jump_chg;
  logic        press;
  logic        trip;
  logic [7:0]  trip_code;
  logic        done;
  logic [25:0] lim;
  logic [2:0]  ev;
  logic [2:0]  clr;
  logic        rd;
  logic        wr;
  logic [31:0] wm;
  logic [31:0] wv;
  logic [31:0] rv;
  blink_t      first_st;
  logic [3:0]  first_left;
  logic        first_slow;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st   = st;
    trip      = 1'b0;
    trip_code = 8'h00;
    ev        = 3'b000;
    clr       = 3'b000;
    rv        = 32'h0000_0000;
    next_st.recycle = 1'b0;

    // two-flop synchronisers on pins
    next_st.j1  = jumper_intact_i;
    next_st.j2  = st.j1;
    next_st.b1  = reset_btn_i;
    next_st.b2  = st.b1;
    next_st.b3  = st.b2;
    next_st.sv1 = {lockout_saved_i, saved_code_i};
    next_st.sv2 = st.sv1;
    press       = st.b2 & ~st.b3;

    // second, hour and run-time base
    sec_tick  = (st.pre >= 25'(SEC_CYCLES_P - 1));
    hour_tick = sec_tick && (st.secs >= 12'(HOUR_SECS_P - 1));
    next_st.pre = sec_tick ? 25'd0 : st.pre + 25'd1;
    if (sec_tick) begin
      next_st.secs = hour_tick ? 12'd0 : st.secs + 12'd1;
    end
    if (hour_tick && st.hours != 8'hff) begin
      next_st.hours = st.hours + 8'd1;
    end
    // seconds into run, saturating at the window
    if (!in_run_i) begin
      next_st.run_s = 4'd0;
    end else if (sec_tick && st.run_s < 4'(RUN_WINDOW_S)) begin
      next_st.run_s = st.run_s + 4'd1;
    end

    // catch straps once the synchronisers have filled
    if (!st.started) begin
      if (st.start == 2'(START_WAIT)) begin
        next_st.started = 1'b1;
        next_st.jsamp   = st.j2;
        next_st.pilot_s = st.j2[0] ? PILOT_INTACT_S
                                   : PILOT_CLIPPED_S;
        if (st.sv2[8]) begin
          next_st.locked = 1'b1;
          next_st.code   = st.sv2[7:0];
          next_st.perm   = (st.sv2[7:0] == CODE_110);
        end
      end else begin
        next_st.start = st.start + 2'd1;
      end
    end

    // fault detection; the first fault is held until cleared or until a late jumper change replaces it with fault 110
    jump_chg = st.started && (st.j2 != st.jsamp);
    if (jump_chg && st.hours >= 8'(HOURS_LIMIT)) begin
      if (!st.perm) begin
        next_st.perm   = 1'b1;
        next_st.locked = 1'b1;
        next_st.code   = CODE_110;
        ev[IRQ_PERM]   = 1'b1;
        ev[IRQ_LOCK]   = 1'b1;
      end
    end else if (st.started && !st.locked) begin
      if (jump_chg) begin
        trip      = 1'b1;
        trip_code = CODE_JUMPER;
      end else if (flame_present_i && standby_purge_i) begin
        trip      = 1'b1;
        trip_code = CODE_FALSE_FLAME;
      end else if (flame_level_i > st.fmax) begin
        trip      = 1'b1;
        trip_code = CODE_OVERRANGE;
      end else if (airflow_fail_i) begin
        if (!st.jsamp[2]) begin
          trip      = 1'b1;
          trip_code = CODE_AIRFLOW;
        end else begin
          next_st.recycle = 1'b1;
        end
      end else if (flame_fail_i) begin
        if (!st.jsamp[1] &&
            !(st.special && st.run_s >= 4'(RUN_WINDOW_S))) begin
          trip      = 1'b1;
          trip_code = CODE_NO_FLAME;
        end else begin
          next_st.recycle = 1'b1;
        end
      end
    end else if (st.locked && !st.perm && press) begin
      next_st.locked = 1'b0;
      next_st.code   = 8'h00;
    end
    if (trip) begin
      next_st.locked = 1'b1;
      next_st.code   = trip_code;
      ev[IRQ_LOCK]   = 1'b1;
    end
    ev[IRQ_RECYCLE] = next_st.recycle;

    // blink pattern: tens fast, gap, units slow, pause, repeat
    if (st.code[7:4] != 4'h0) begin
      first_st   = B_ON;
      first_left = st.code[7:4];
      first_slow = 1'b0;
    end else if (st.code[3:0] != 4'h0) begin
      first_st   = B_ON;
      first_left = st.code[3:0];
      first_slow = 1'b1;
    end else begin
      first_st   = B_PAUSE;
      first_left = 4'h0;
      first_slow = 1'b0;
    end
    if (st.bst == B_ON || st.bst == B_OFF) begin
      lim = st.slow_ph ? st.slow : st.fast;
    end else begin
      lim = st.pause;
    end
    done = (st.cnt + 26'd1 >= lim);
    next_st.cnt = done ? 26'd0 : st.cnt + 26'd1;
    case (st.bst)
      B_IDLE: begin
        next_st.led = 1'b1;
        next_st.cnt = 26'd0;
        // open dark so the first blink is not lost in steady light
        if (st.locked) begin
          next_st.bst = B_PAUSE;
          next_st.led = 1'b0;
        end
      end
      B_ON: begin
        if (done) begin
          next_st.bst = B_OFF;
          next_st.led = 1'b0;
        end
      end
      B_OFF: begin
        if (done) begin
          if (st.left > 4'd1) begin
            next_st.left = st.left - 4'd1;
            next_st.bst  = B_ON;
            next_st.led  = 1'b1;
          end else if (!st.slow_ph && st.code[3:0] != 4'h0) begin
            next_st.bst = B_GAP;
          end else begin
            next_st.bst = B_PAUSE;
          end
        end
      end
      B_GAP: begin
        if (done) begin
          next_st.bst     = B_ON;
          next_st.slow_ph = 1'b1;
          next_st.left    = st.code[3:0];
          next_st.led     = 1'b1;
        end
      end
      B_PAUSE: begin
        if (done) begin
          next_st.bst     = first_st;
          next_st.left    = first_left;
          next_st.slow_ph = first_slow;
          next_st.led     = (first_st == B_ON);
        end
      end
      default: begin
        next_st.bst = B_IDLE;
      end
    endcase
    // fault cleared: steady power indication
    if (!next_st.locked) begin
      next_st.bst = B_IDLE;
      next_st.led = 1'b1;
      next_st.cnt = 26'd0;
    end

    // wishbone: data and ack one cycle after the strobe
    rd = wb_cyc_i && wb_stb_i && !st.ack;
    wr = wb_cyc_i && wb_stb_i && wb_we_i && st.ack;
    next_st.ack = rd;
    wm = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
          {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wv = wb_dat_i & wm;
    if (wb_adr_i == CTRL_OFS) begin
      rv = {31'h0, st.special};
      if (wr && wb_sel_i[0]) next_st.special = wb_dat_i[0];
    end else if (wb_adr_i == STATUS_OFS) begin
      rv = {st.hours, st.code, 1'b0, st.jsamp, st.pilot_s,
            5'h00, st.started, st.perm, st.locked};
    end else if (wb_adr_i == IRQ_STAT_OFS) begin
      rv = {29'h0, st.irq};
      if (wr) clr = wv[2:0];
    end else if (wb_adr_i == IRQ_MASK_OFS) begin
      rv = {29'h0, st.mask};
      if (wr && wb_sel_i[0]) next_st.mask = wb_dat_i[2:0];
    end else if (wb_adr_i == FAST_OFS) begin
      rv = {6'h00, st.fast};
      if (wr) next_st.fast = 26'((st.fast & ~wm) | wv);
    end else if (wb_adr_i == SLOW_OFS) begin
      rv = {6'h00, st.slow};
      if (wr) next_st.slow = 26'((st.slow & ~wm) | wv);
    end else if (wb_adr_i == PAUSE_OFS) begin
      rv = {6'h00, st.pause};
      if (wr) next_st.pause = 26'((st.pause & ~wm) | wv);
    end else if (wb_adr_i == FLAME_MAX_OFS) begin
      rv = {24'h0, st.fmax};
      if (wr && wb_sel_i[0]) next_st.fmax = wb_dat_i[7:0];
    end
    if (rd) next_st.dat = rv;

    // sticky events: a new event wins over the clearing write
    next_st.irq     = (st.irq & ~clr) | ev;
    next_st.irq_out = |(next_st.irq & next_st.mask);
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st         <= '0;
      st.led     <= 1'b1;
      st.fast    <= 26'(FAST_CYCLES);
      st.slow    <= 26'(SLOW_CYCLES);
      st.pause   <= 26'(PAUSE_CYCLES);
      st.fmax    <= FLAME_MAX_RST;
      st.pilot_s <= PILOT_INTACT_S;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs straight from flops
  // ---------------------------------------------------------------
  assign wb_dat_o         = st.dat;
  assign wb_ack_o         = st.ack;
  assign irq_o            = st.irq_out;
  assign power_led_o      = st.led;
  assign lockout_o        = st.locked;
  assign fault_code_o     = st.code;
  assign recycle_o        = st.recycle;
  assign pilot_period_s_o = st.pilot_s;

endmodule : fault_blink_annunciator

// >>> blink_asserts.sv
// port assertions for the fault blink annunciator
`timescale 1ns/1ps
module blink_asserts (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  // bus handshake
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  // panel and indications
  input wire logic       reset_btn_i,
  input wire logic       power_led_o,
  input wire logic       lockout_o,
  input wire logic [7:0] fault_code_o,
  input wire logic       recycle_o,
  input wire logic [3:0] pilot_period_s_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // --------------------
  // sequences
  // --------------------
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // a press that is allowed to clear the lockout
  sequence s_press;
    $rose(reset_btn_i) && lockout_o && fault_code_o != 8'hb0;
  endsequence

  // --------------------
  // properties
  // --------------------
  property p_ack_next;
    s_req |=> wb_ack_o;
  endproperty
  property p_ack_one;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  // led may lag the lockout release by one cycle
  property p_led_lit;
    !lockout_o && !$past(lockout_o) |-> power_led_o;
  endproperty
  property p_code_clear;
    !lockout_o |-> fault_code_o == 8'h00;
  endproperty
  property p_perm;
    lockout_o && fault_code_o == 8'hb0 |=> lockout_o && fault_code_o == 8'hb0;
  endproperty
  property p_press;
    s_press |-> ##[1:4] !lockout_o;
  endproperty
  property p_recycle;
    recycle_o |=> !recycle_o;
  endproperty
  property p_pilot;
    pilot_period_s_o == 4'ha || pilot_period_s_o == 4'h4;
  endproperty
  // a fresh lockout starts with the indicator dark
  property p_dark;
    $rose(lockout_o) |=> !power_led_o;
  endproperty

  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  a_led_lit: assert property (p_led_lit) else $error("led dark");
  a_code_clear: assert property (p_code_clear) else $error("code");
  a_perm: assert property (p_perm) else $error("fault 110 lost");
  a_press: assert property (p_press) else $error("press ignored");
  a_recycle: assert property (p_recycle) else $error("recycle");
  a_pilot: assert property (p_pilot) else $error("pilot period");
  a_dark: assert property (p_dark) else $error("led lit");
endmodule : blink_asserts

bind fault_blink_annunciator blink_asserts u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .reset_btn_i(reset_btn_i),
  .power_led_o(power_led_o), .lockout_o(lockout_o),
  .fault_code_o(fault_code_o), .recycle_o(recycle_o),
  .pilot_period_s_o(pilot_period_s_o)
);

// >>> panel_model.sv
// panel model: jumpers, reset button and a blink decoder on the led
`timescale 1ns/1ps
module panel_model #(
  parameter int FAST_P = 2,
  parameter int SLOW_P = 5,
  parameter int GAP_P  = 10
) (
  // clock
  input  wire logic       clk_i,
  // panel pins
  input  wire logic       power_led_i,
  output logic      [2:0] jumper_intact_o,
  output logic            reset_btn_o,
  // decoded code and repetition count
  output logic      [7:0] code_seen_o,
  output logic      [7:0] reps_o
);
  int         on_len = 0;
  int         off_len = 0;
  logic [3:0] tens = 4'h0;
  logic [3:0] units = 4'h0;

  // all jumpers intact, button up
  initial begin
    jumper_intact_o = 3'h7;
    reset_btn_o = 1'b0;
    code_seen_o = 8'h00;
    reps_o = 8'h00;
  end

  // held for several cycles so the synchroniser surely sees it
  task automatic press();
    @(posedge clk_i);
    reset_btn_o <= 1'b1;
    repeat (6) @(posedge clk_i);
    reset_btn_o <= 1'b0;
  endtask : press

  task automatic set_jumpers(input logic [2:0] j);
    @(posedge clk_i);
    jumper_intact_o <= j;
  endtask : set_jumpers

  // short on-times count tens, long ones units; only exact widths count
  always @(posedge clk_i) begin
    if (power_led_i) begin
      on_len <= on_len + 1;
      off_len <= 0;
      if (on_len > 2 * SLOW_P) begin
        tens <= 4'h0;
        units <= 4'h0;
      end
    end else begin
      if (on_len == FAST_P) tens <= tens + 4'h1;
      if (on_len == SLOW_P) units <= units + 4'h1;
      on_len <= 0;
      off_len <= off_len + 1;
      if (off_len == GAP_P && units != 4'h0) begin
        code_seen_o <= {tens, units};
        reps_o <= reps_o + 8'h01;
        tens <= 4'h0;
        units <= 4'h0;
      end
    end
  end
endmodule : panel_model

// >>> tb.sv
// self-checking testbench for the fault blink annunciator
`timescale 1ns/1ps
module tb;
  import blink_pkg::*;
  // --------------------
  // signals
  // --------------------
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic        saved = 1'b0;
  logic [7:0]  saved_code = 8'h00;
  logic        flame = 1'b0;
  logic        purge = 1'b0;
  logic        run = 1'b0;
  logic [7:0]  level = 8'h00;
  logic [1:0]  evp = 2'b00;
  logic [3:0]  sel = 4'hf;
  logic [3:0]  wsel = 4'hf;
  logic [7:0]  seen, reps;
  logic [31:0] rdat, q;
  logic [2:0]  jmp;
  logic        ack, irq, btn, led, lock, recyc;
  logic [7:0]  code;
  logic [3:0]  pilot;
  int          r0;
  int          fail_count = 0;
  int          tests_run = 0;

  // 20 MHz system clock
  always #25 clk_i = ~clk_i;

  // one second is 10 cycles and one hour 2 seconds, so 200 h is 4000
  fault_blink_annunciator #(.SEC_CYCLES_P(10), .HOUR_SECS_P(2)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq),
    .jumper_intact_i(jmp), .reset_btn_i(btn), .lockout_saved_i(saved),
    .saved_code_i(saved_code), .flame_present_i(flame),
    .standby_purge_i(purge), .in_run_i(run), .flame_level_i(level),
    .flame_fail_i(evp[0]), .airflow_fail_i(evp[1]),
    .power_led_o(led), .lockout_o(lock), .fault_code_o(code),
    .recycle_o(recyc), .pilot_period_s_o(pilot));

  panel_model pnl (.clk_i(clk_i), .power_led_i(led), .jumper_intact_o(jmp),
    .reset_btn_o(btn), .code_seen_o(seen), .reps_o(reps));

  // --------------------
  // tasks
  // --------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      fail_count++;
    end
  endtask : chk

  // classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= wsel;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    we <= 1'b0;
    chk("wb ack", ack, 1'b1);
    if (ack !== 1'b1) end_sim();
  endtask : wb

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step

  task automatic drv(input logic p, f, r, input logic [7:0] l);
    @(posedge clk_i);
    purge <= p;
    flame <= f;
    run <= r;
    level <= l;
  endtask : drv

  task automatic fire(input int b);
    @(posedge clk_i);
    evp[b] <= 1'b1;
    @(posedge clk_i);
    evp <= 2'b00;
    #1;
  endtask : fire

  task automatic wait_lk(input logic v, input logic [7:0] c);
    int n;
    for (n = 0; n < 300 && lock !== v; n++)
      @(posedge clk_i);
    #1;
    chk("lockout", lock, v);
    chk("fault code", code, c);
    if (lock !== v) end_sim();
  endtask : wait_lk

  task automatic setup(input logic [2:0] j, input logic s, input logic [7:0] c);
    pnl.set_jumpers(j);
    saved <= s;
    saved_code <= c;
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    wb(1'b1, FAST_OFS, 32'd2);
    wb(1'b1, SLOW_OFS, 32'd5);
    wb(1'b1, PAUSE_OFS, 32'd12);
    wb(1'b1, IRQ_MASK_OFS, 32'd1);
    step(1);
  endtask : setup

  // --------------------
  // test sequence
  // --------------------
  initial begin
    setup(3'h7, 1'b0, 8'h00);
    chk("led", led, 1'b1);
    chk("pilot", pilot, PILOT_INTACT_S);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", q, 32'h0);
    wsel = 4'h1;
    wb(1'b1, FAST_OFS, 32'hffff_ff03);
    wsel = 4'hf;
    wb(1'b0, FAST_OFS, 32'h0);
    chk("fast lane", q, 32'h3);
    wb(1'b1, FAST_OFS, 32'd2);
    fire(0);
    chk("flame recycle", recyc, 1'b1);
    fire(1);
    chk("air recycle", recyc, 1'b1);
    chk("no lock", lock, 1'b0);
    $display("test intact jumpers done");
    drv(1'b1, 1'b1, 1'b0, 8'h00);
    wait_lk(1'b1, CODE_FALSE_FLAME);
    drv(1'b0, 1'b0, 1'b0, 8'h00);
    r0 = reps;
    for (int n = 0; n < 400 && reps < r0 + 2; n++)
      @(posedge clk_i);
    chk("blink", seen, CODE_FALSE_FLAME);
    chk("repeats", reps >= r0 + 2, 1'b1);
    if (reps < r0 + 2) end_sim();
    chk("irq", irq, 1'b1);
    wb(1'b1, IRQ_STAT_OFS, 32'h7);
    step(2);
    chk("irq clear", irq, 1'b0);
    wb(1'b0, STATUS_OFS, 32'h0);
    chk("status code", q[23:16], CODE_FALSE_FLAME);
    pnl.press();
    wait_lk(1'b0, 8'h00);
    step(2);
    chk("led after", led, 1'b1);
    $display("test blink and clear done");
    drv(1'b0, 1'b0, 1'b0, FLAME_MAX_RST);
    step(6);
    chk("at max", lock, 1'b0);
    drv(1'b0, 1'b0, 1'b0, FLAME_MAX_RST + 8'h01);
    wait_lk(1'b1, CODE_OVERRANGE);
    drv(1'b0, 1'b0, 1'b0, 8'h00);
    step(2);
    chk("irq on", irq, 1'b1);
    wb(1'b1, IRQ_MASK_OFS, 32'h0);
    step(2);
    chk("irq masked", irq, 1'b0);
    pnl.press();
    wait_lk(1'b0, 8'h00);
    pnl.set_jumpers(3'h3);
    wait_lk(1'b1, CODE_JUMPER);
    pnl.set_jumpers(3'h7);
    pnl.press();
    wait_lk(1'b0, 8'h00);
    $display("test overrange and jumper done");
    setup(3'h0, 1'b0, 8'h00);
    chk("pilot", pilot, PILOT_CLIPPED_S);
    fire(0);
    wait_lk(1'b1, CODE_NO_FLAME);
    pnl.press();
    wait_lk(1'b0, 8'h00);
    fire(1);
    wait_lk(1'b1, CODE_AIRFLOW);
    pnl.press();
    wait_lk(1'b0, 8'h00);
    wb(1'b1, CTRL_OFS, 32'h1);
    drv(1'b0, 1'b1, 1'b1, 8'h00);
    fire(0);
    wait_lk(1'b1, CODE_NO_FLAME);
    pnl.press();
    wait_lk(1'b0, 8'h00);
    step(170);
    fire(0);
    chk("late loss", recyc, 1'b1);
    step(3);
    chk("late lock", lock, 1'b0);
    $display("test clipped jumpers done");
    step(4000);
    pnl.set_jumpers(3'h1);
    wait_lk(1'b1, CODE_110);
    pnl.press();
    step(12);
    chk("perm code", code, CODE_110);
    $display("test late jumper done");
    setup(3'h7, 1'b1, CODE_OVERRANGE);
    wait_lk(1'b1, CODE_OVERRANGE);
    pnl.press();
    wait_lk(1'b0, 8'h00);
    $display("test restored lockout done");
    end_sim();
  end
endmodule : tb
